//--- design/apm_pkg.sv
// Constants, field layouts and path codes for the receive-path mode configuration.
// Assumes a single 40 MHz clock and a 16-bit register port behind the serial control port.
package apm_pkg;

    // ------------------------------------------------------------
    // register port
    // ------------------------------------------------------------
    localparam int ADDR_W = 8;
    localparam int DATA_W = 16;

    localparam logic [7:0] OFS_INPUT_SEL = 8'h14;
    localparam logic [7:0] OFS_TRIM_A    = 8'h42;
    localparam logic [7:0] OFS_PATH_A    = 8'h43;
    localparam logic [7:0] OFS_TRIM_B    = 8'h44;
    localparam logic [7:0] OFS_PATH_B    = 8'h45;
    localparam logic [7:0] OFS_GLOBAL    = 8'h58;

    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int SETTING_LSB     = 10;
    localparam int GAIN_BIT        = 9;
    localparam int FOLLOWER_BIT    = 7;
    localparam int BIAS_LSB        = 4;
    localparam int GLOBAL_FOLLOWER = 7;
    localparam int PD_SEL_LSB_A    = 4;
    localparam int PD_SEL_LSB_B    = 8;
    localparam int PULSE_SEL_LSB_A = 0;
    localparam int PULSE_SEL_LSB_B = 2;

    // ------------------------------------------------------------
    // path codes and reset values
    // ------------------------------------------------------------
    localparam logic [15:0] PATH_CODE_FULL          = 16'hADA5;
    localparam logic [15:0] PATH_CODE_SKIP_BANDPASS = 16'hAE65;
    localparam logic [15:0] PATH_CODE_SKIP_ALL      = 16'hB065;
    localparam logic [5:0]  SETTING_NORMAL          = 6'h07;

    localparam logic [15:0] RST_TRIM      = 16'h1C00;
    localparam logic [15:0] RST_PATH      = 16'hADA5;
    localparam logic [15:0] RST_GLOBAL    = 16'h0000;
    localparam logic [15:0] RST_INPUT_SEL = 16'h0000;

    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_NS       = 25;
    localparam int CHANNEL_SPACING_NS  = 1000;
    localparam int CHANNEL_SPACING_CYC =
        (CHANNEL_SPACING_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int NS_PER_US           = 1000;
    localparam int CYC_PER_US          = NS_PER_US / CLK_PERIOD_NS;
    localparam logic [5:0]  SPACING_LAST = 6'(CHANNEL_SPACING_CYC - 1);
    localparam logic [15:0] CYC_PER_US_W = 16'(CYC_PER_US);
    localparam logic [1:0]  LAST_CHANNEL = 2'h3;

    typedef enum logic [1:0] {
        PATH_FULL        = 2'b00,
        PATH_NO_BANDPASS = 2'b01,
        PATH_NO_BOTH     = 2'b11
    } apm_path_t;

    // path word decode, unknown words treated as full path
    function automatic apm_path_t apm_decode_path(input logic [15:0] word);
        apm_path_t p;
        p = PATH_FULL;
        if (word == PATH_CODE_SKIP_BANDPASS) begin
            p = PATH_NO_BANDPASS;
        end else if (word == PATH_CODE_SKIP_ALL) begin
            p = PATH_NO_BOTH;
        end
        return p;
    endfunction : apm_decode_path

endpackage : apm_pkg

//--- design/apm_slot_timer.sv
// Per-slot timer: pulse window and direct-mode channel sampling sequence.
// Assumes slot_go is a one-cycle pulse from the time-slot sequencer.
`timescale 1ns/10ps
module apm_slot_timer
    import apm_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       rst_b,
    input  wire logic       slot_go,
    input  wire logic [7:0] pulse_width_us,
    input  wire logic       direct_mode,
    output logic            pulse_active,
    output logic            adc_strobe,
    output logic [1:0]      adc_channel
);
    import apm_pkg::*;

    typedef struct packed {
        logic [15:0] pulse_cnt;
        logic        pulse_active;
        logic        seq_busy;
        logic [5:0]  spacing;
        logic [1:0]  chan;
        logic        strobe;
    } apm_timer_t;

    apm_timer_t s;
    apm_timer_t next_s;

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        next_s = s;
        next_s.strobe = 1'b0;
        // pulse window lasts exactly the programmed width
        if (slot_go) begin
            next_s.pulse_cnt    = 16'(pulse_width_us * CYC_PER_US_W);
            next_s.pulse_active = (pulse_width_us != 8'h00);
        end else if (s.pulse_active) begin
            if (s.pulse_cnt == 16'h0001) begin
                next_s.pulse_active = 1'b0;
                next_s.pulse_cnt    = 16'h0000;
            end else begin
                next_s.pulse_cnt = s.pulse_cnt - 16'h0001;
            end
        end
        // four channel samples spaced one microsecond
        if (s.seq_busy) begin
            if (s.spacing == SPACING_LAST) begin
                next_s.spacing = 6'h00;
                if (s.chan == LAST_CHANNEL) begin
                    next_s.seq_busy = 1'b0;
                end else begin
                    next_s.chan   = s.chan + 2'h1;
                    next_s.strobe = 1'b1;
                end
            end else begin
                next_s.spacing = s.spacing + 6'h01;
            end
        end
        if (slot_go && direct_mode) begin
            next_s.seq_busy = 1'b1;
            next_s.chan     = 2'h0;
            next_s.spacing  = 6'h00;
            next_s.strobe   = 1'b1;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign pulse_active = s.pulse_active;
    assign adc_strobe   = s.strobe;
    assign adc_channel  = s.chan;

endmodule : apm_slot_timer

//--- design/apm_path_config.sv
// Receive-path mode configuration for two time slots: registers and path controls.
// Assumes the serial control port delivers decoded 16-bit register accesses.
`timescale 1ns/10ps
module apm_path_config
    import apm_pkg::*;
(
    input  wire logic                    clk,
    input  wire logic                    rst_b,
    input  wire logic [apm_pkg::ADDR_W-1:0] reg_addr,
    input  wire logic [apm_pkg::DATA_W-1:0] reg_wdata,
    input  wire logic                    reg_wr,
    input  wire logic                    reg_rd,
    output logic [apm_pkg::DATA_W-1:0]   reg_rdata,
    output logic                         reg_rvalid,
    input  wire logic [1:0]              slot_go,
    input  wire logic [7:0]              led_width_us_a,
    input  wire logic [7:0]              led_width_us_b,
    output logic [1:0]                   bandpass_bypass,
    output logic [1:0]                   integrator_bypass,
    output logic [1:0]                   integrator_follower_on,
    output logic [1:0]                   follower_gain_low,
    output logic [1:0][1:0]              transimpedance_bias_select,
    output logic [1:0][5:0]              integrator_setting,
    output logic [1:0]                   direct_conversion_mode,
    output logic [1:0]                   pulse_connect_mode,
    output logic [1:0]                   input_switch_closed,
    output logic [1:0]                   led_fire,
    output logic [1:0]                   adc_sample,
    output logic [1:0][1:0]              adc_channel
);
    import apm_pkg::*;

    typedef struct packed {
        logic [1:0][15:0] trim;
        logic [1:0][15:0] path;
        logic [15:0]      global_cfg;
        logic [15:0]      input_sel;
        logic [15:0]      rdata;
        logic             rvalid;
        logic [1:0]       bandpass_byp;
        logic [1:0]       int_byp;
        logic [1:0]       follower;
        logic [1:0]       gain_low;
        logic [1:0][1:0]  bias;
        logic [1:0][5:0]  setting;
        logic [1:0]       direct;
        logic [1:0]       pconnect;
        logic [1:0]       sw_closed;
        logic [1:0]       led;
        logic [1:0]       sample;
        logic [1:0][1:0]  chan;
    } apm_state_t;

    apm_state_t s;
    apm_state_t next_s;

    logic [1:0]      tmr_pulse;
    logic [1:0]      tmr_strobe;
    logic [1:0][1:0] tmr_chan;
    logic [1:0][7:0] width_us;

    assign width_us[0] = led_width_us_a;
    assign width_us[1] = led_width_us_b;

    // ------------------------------------------------------------
    // per-slot timers
    // ------------------------------------------------------------
    for (genvar g = 0; g < 2; g++) begin : g_slot
        apm_slot_timer u_timer (
            .clk            (clk),
            .rst_b          (rst_b),
            .slot_go        (slot_go[g]),
            .pulse_width_us (width_us[g]),
            .direct_mode    (s.direct[g]),
            .pulse_active   (tmr_pulse[g]),
            .adc_strobe     (tmr_strobe[g]),
            .adc_channel    (tmr_chan[g])
        );
    end

    // ------------------------------------------------------------
    // register access and path decode
    // ------------------------------------------------------------
    always_comb begin
        apm_path_t  mode;
        logic [3:0] pd_nibble;
        logic [1:0] pulse_sel;
        next_s = s;
        mode      = PATH_FULL;
        pd_nibble = 4'h0;
        pulse_sel = 2'h0;

        if (reg_wr) begin
            unique case (reg_addr)
                OFS_TRIM_A:    next_s.trim[0]    = reg_wdata;
                OFS_PATH_A:    next_s.path[0]    = reg_wdata;
                OFS_TRIM_B:    next_s.trim[1]    = reg_wdata;
                OFS_PATH_B:    next_s.path[1]    = reg_wdata;
                OFS_GLOBAL:    next_s.global_cfg = reg_wdata;
                OFS_INPUT_SEL: next_s.input_sel  = reg_wdata;
                default:       next_s.rdata      = s.rdata;
            endcase
        end

        next_s.rvalid = reg_rd;
        if (reg_rd) begin
            unique case (reg_addr)
                OFS_TRIM_A:    next_s.rdata = s.trim[0];
                OFS_PATH_A:    next_s.rdata = s.path[0];
                OFS_TRIM_B:    next_s.rdata = s.trim[1];
                OFS_PATH_B:    next_s.rdata = s.path[1];
                OFS_GLOBAL:    next_s.rdata = s.global_cfg;
                OFS_INPUT_SEL: next_s.rdata = s.input_sel;
                default:       next_s.rdata = 16'h0000;
            endcase
        end

        for (int i = 0; i < 2; i++) begin
            mode = apm_decode_path(s.path[i]);
            if (i == 0) begin
                pd_nibble = s.input_sel[PD_SEL_LSB_A +: 4];
                pulse_sel = s.input_sel[PULSE_SEL_LSB_A +: 2];
            end else begin
                pd_nibble = s.input_sel[PD_SEL_LSB_B +: 4];
                pulse_sel = s.input_sel[PULSE_SEL_LSB_B +: 2];
            end

            next_s.bandpass_byp[i] = (mode != PATH_FULL);
            next_s.int_byp[i] = (mode == PATH_NO_BOTH);
            next_s.direct[i]  = (mode != PATH_FULL);
            // follower only with per-slot bit, global enable and bandpass skip
            next_s.follower[i] = s.trim[i][FOLLOWER_BIT]
                               & s.global_cfg[GLOBAL_FOLLOWER]
                               & (mode == PATH_NO_BANDPASS);
            next_s.gain_low[i] = s.trim[i][GAIN_BIT];
            next_s.bias[i]     = s.trim[i][BIAS_LSB +: 2];
            // setting only drives the integrator in full-path operation
            next_s.setting[i]  = (mode == PATH_FULL) ?
                                 s.trim[i][SETTING_LSB +: 6] : 6'h00;

            // pulse connect: full path with the slot's two pulse-select bits of input_sel cleared
            next_s.pconnect[i] = (mode == PATH_FULL) && (pulse_sel == 2'h0);

            if (pd_nibble == 4'h0) begin
                next_s.sw_closed[i] = 1'b0;
            end else if (next_s.pconnect[i]) begin
                next_s.sw_closed[i] = tmr_pulse[i];
            end else begin
                next_s.sw_closed[i] = 1'b1;
            end
            next_s.led[i] = tmr_pulse[i] & ~next_s.pconnect[i];

            next_s.sample[i] = tmr_strobe[i];
            next_s.chan[i]   = tmr_chan[i];
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            s            <= '0;
            s.trim       <= {RST_TRIM, RST_TRIM};
            s.path       <= {RST_PATH, RST_PATH};
            s.global_cfg <= RST_GLOBAL;
            s.input_sel  <= RST_INPUT_SEL;
        end else begin
            s <= next_s;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign reg_rdata                  = s.rdata;
    assign reg_rvalid                 = s.rvalid;
    assign bandpass_bypass            = s.bandpass_byp;
    assign integrator_bypass          = s.int_byp;
    assign integrator_follower_on     = s.follower;
    assign follower_gain_low          = s.gain_low;
    assign transimpedance_bias_select = s.bias;
    assign integrator_setting         = s.setting;
    assign direct_conversion_mode     = s.direct;
    assign pulse_connect_mode         = s.pconnect;
    assign input_switch_closed        = s.sw_closed;
    assign led_fire                   = s.led;
    assign adc_sample                 = s.sample;
    assign adc_channel                = s.chan;

endmodule : apm_path_config

//--- dv/apm_path_config_asserts.sv
// Bound checker for the receive-path mode configuration block.
// Assumes one clock domain; sees only the top module's ports.
`timescale 1ns/10ps
module apm_path_config_asserts (
    input wire logic            clk,
    input wire logic            rst_b,
    input wire logic [7:0]      reg_addr,
    input wire logic [15:0]     reg_wdata,
    input wire logic            reg_wr,
    input wire logic [1:0]      bandpass_bypass,
    input wire logic [1:0]      integrator_bypass,
    input wire logic [1:0]      integrator_follower_on,
    input wire logic [1:0]      follower_gain_low,
    input wire logic [1:0][1:0] transimpedance_bias_select,
    input wire logic [1:0][5:0] integrator_setting,
    input wire logic [1:0]      direct_conversion_mode,
    input wire logic [1:0]      pulse_connect_mode,
    input wire logic [1:0]      input_switch_closed,
    input wire logic [1:0]      led_fire
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_b);
    // writes per address; a repeat write next cycle would mask the first
    wire w14 = reg_wr && reg_addr == 8'h14;
    wire w42 = reg_wr && reg_addr == 8'h42;
    wire w43 = reg_wr && reg_addr == 8'h43;
    wire w45 = reg_wr && reg_addr == 8'h45;
    wire w58 = reg_wr && reg_addr == 8'h58;
    property p_skip_bpf;
        w43 && reg_wdata == 16'hAE65 ##1 !w43 |-> ##1 bandpass_bypass[0] && !integrator_bypass[0];
    endproperty
    a_skip_bpf: assert property (p_skip_bpf) else $error("slot a skip");
    property p_skip_all;
        w45 && reg_wdata == 16'hB065 ##1 !w45 |-> ##1 integrator_bypass[1] && bandpass_bypass[1];
    endproperty
    a_skip_all: assert property (p_skip_all) else $error("slot b skip");
    property p_follower_off;
        w58 && !reg_wdata[7] ##1 !w58 |-> ##1 integrator_follower_on == 2'b00;
    endproperty
    a_follower_off: assert property (p_follower_off) else $error("follower");
    property p_gain;
        w42 ##1 !w42 |-> ##1 follower_gain_low[0] == $past(reg_wdata[9], 2);
    endproperty
    a_gain: assert property (p_gain) else $error("gain");
    property p_bias;
        w42 ##1 !w42 |-> ##1 transimpedance_bias_select[0] == $past(reg_wdata[5:4], 2);
    endproperty
    a_bias: assert property (p_bias) else $error("bias");
    property p_setting;
        direct_conversion_mode[1] |-> integrator_setting[1] == 6'h00;
    endproperty
    a_setting: assert property (p_setting) else $error("setting");
    property p_no_led;
        led_fire[0] |-> !pulse_connect_mode[0];
    endproperty
    a_no_led: assert property (p_no_led) else $error("led in pulse mode");
    property p_disconnect;
        w14 && reg_wdata[7:4] == 4'h0 ##1 !w14 |-> ##1 !input_switch_closed[0];
    endproperty
    a_disconnect: assert property (p_disconnect) else $error("switch");
endmodule : apm_path_config_asserts

//--- dv/apm_host_model.sv
// Host model driving the register port of the path configuration block.
// Assumes one caller at a time; idle bus shows inverted last values.
`timescale 1ns/10ps
module apm_host_model (
    input  wire logic  clk,
    output logic [7:0]  reg_addr,
    output logic [15:0] reg_wdata,
    output logic        reg_wr,
    output logic        reg_rd
);
    initial begin
        reg_addr = 8'h00;
        reg_wdata = 16'h0000;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
    end
    task automatic xfer(input logic [7:0] a, input logic [15:0] d, input logic w);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= w;
        reg_rd <= !w;
        @(posedge clk);
        reg_wr <= 1'b0;
        reg_rd <= 1'b0;
        reg_addr <= ~a;
        reg_wdata <= ~d;
    endtask : xfer
endmodule : apm_host_model

//--- dv/tb.sv
// Self-checking bench for the receive-path mode configuration block.
// Assumes the host model drives the register port; the checker is bound below.
`timescale 1ns/10ps
module tb;
    import apm_pkg::*;
    logic            clk = 1'b0;
    logic            rst_b = 1'b0;
    logic [1:0]      slot_go = 2'b00;
    logic [7:0]      led_width_us_a = 8'h02;
    logic [7:0]      led_width_us_b = 8'h02;
    logic [7:0]      reg_addr;
    logic [15:0]     reg_wdata;
    logic            reg_wr;
    logic            reg_rd;
    logic [15:0]     reg_rdata;
    logic            reg_rvalid;
    logic [1:0]      bandpass_bypass;
    logic [1:0]      integrator_bypass;
    logic [1:0]      integrator_follower_on;
    logic [1:0]      follower_gain_low;
    logic [1:0][1:0] transimpedance_bias_select;
    logic [1:0][5:0] integrator_setting;
    logic [1:0]      direct_conversion_mode;
    logic [1:0]      pulse_connect_mode;
    logic [1:0]      input_switch_closed;
    logic [1:0]      led_fire;
    logic [1:0]      adc_sample;
    logic [1:0][1:0] adc_channel;
    int              err_count = 0;
    int              n_compared = 0;
    int              seed = 32'h29DA7A01;
    int              cnt [4];
    int              ts [$];
    logic [15:0]     exp_q [$];
    logic [15:0]     code [3] = '{PATH_CODE_FULL, PATH_CODE_SKIP_BANDPASS, PATH_CODE_SKIP_ALL};
    logic [7:0]      ofs [5] = '{OFS_TRIM_A, OFS_PATH_A, OFS_TRIM_B, OFS_GLOBAL, 8'h50};
    logic [15:0]     rst_v [5] = '{RST_TRIM, RST_PATH, RST_TRIM, RST_GLOBAL, 16'h0000};
    apm_host_model apm_host_model_i (.clk, .reg_addr, .reg_wdata, .reg_wr, .reg_rd);
    apm_path_config apm_path_config_i (
        .clk, .rst_b, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .reg_rvalid,
        .slot_go, .led_width_us_a, .led_width_us_b, .bandpass_bypass, .integrator_bypass,
        .integrator_follower_on, .follower_gain_low, .transimpedance_bias_select,
        .integrator_setting, .direct_conversion_mode, .pulse_connect_mode,
        .input_switch_closed, .led_fire, .adc_sample, .adc_channel);
    always #12.5 clk = ~clk;
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_compared++;
        if (got !== exp) begin
            err_count++;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    task automatic end_sim;
        $display("errors %0d compared %0d", err_count, n_compared);
        if (err_count == 0 && n_compared > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : end_sim
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        apm_host_model_i.xfer(a, d, 1'b1);
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [15:0] e);
        exp_q.push_back(e);
        apm_host_model_i.xfer(a, 16'h0000, 1'b0);
        for (int i = 0; i < 8 && exp_q.size() != 0; i++) @(negedge clk);
        if (exp_q.size() != 0) begin
            err_count++;
            end_sim();
        end
    endtask : rd
    // one slot start, then 200 cycles of window and sample tally
    task automatic run(input logic [1:0] m);
        cnt = '{default: 0};
        ts.delete();
        @(posedge clk);
        slot_go <= m;
        @(posedge clk);
        slot_go <= 2'b00;
        for (int k = 0; k < 200; k++) begin
            @(negedge clk);
            cnt[0] += input_switch_closed[0];
            cnt[2] += led_fire[0];
            cnt[3] += led_fire[1];
            if (adc_sample[0] === 1'b1) begin
                ts.push_back(k);
                chk(adc_channel[0], 16'(ts.size() - 1));
            end
        end
    endtask : run
    always @(negedge clk) begin
        if (reg_rvalid === 1'b1 && exp_q.size() != 0) begin
            chk(reg_rdata, exp_q.pop_front());
        end
    end
    initial begin
        logic [15:0] d;
        logic [15:0] c;
        logic        g;
        logic        b;
        repeat (12) @(posedge clk);
        rst_b <= 1'b1;
        wr(8'h50, 16'hFFFF);
        foreach (ofs[i]) rd(ofs[i], rst_v[i]);
        chk(pulse_connect_mode, 16'h0003);
        $display("reset done");
        for (int i = 0; i < 4; i++) begin
            d = 16'($random(seed));
            wr(ofs[2 * i[0]], d);
            rd(ofs[2 * i[0]], d);
            repeat (3) @(negedge clk);
            chk(follower_gain_low[i[0]], d[9]);
            chk(transimpedance_bias_select[i[0]], d[5:4]);
            chk(integrator_setting[i[0]], d[15:10]);
        end
        $display("trim done");
        wr(OFS_TRIM_A, 16'h1C80);
        wr(OFS_TRIM_B, 16'h1C80);
        for (int i = 0; i < 6; i++) begin
            g = (i >= 3);
            wr(OFS_GLOBAL, {8'h00, g, 7'h00});
            wr(OFS_PATH_A, code[i % 3]);
            wr(OFS_PATH_B, code[(i + 1) % 3]);
            rd(OFS_PATH_B, code[(i + 1) % 3]);
            repeat (3) @(negedge clk);
            for (int s = 0; s < 2; s++) begin
                c = code[(i + s) % 3];
                b = (c != PATH_CODE_FULL);
                chk({bandpass_bypass[s], direct_conversion_mode[s], integrator_bypass[s]},
                    {b, b, c == PATH_CODE_SKIP_ALL});
                chk(integrator_follower_on[s], g && c == PATH_CODE_SKIP_BANDPASS);
                chk(integrator_setting[s], b ? 6'h00 : SETTING_NORMAL);
            end
        end
        $display("path done");
        wr(OFS_PATH_A, PATH_CODE_FULL);
        wr(OFS_PATH_B, PATH_CODE_FULL);
        wr(OFS_INPUT_SEL, 16'h011C);
        repeat (3) @(negedge clk);
        chk(pulse_connect_mode, 16'h0001);
        run(2'b11);
        chk(16'(cnt[0]), 16'(2 * CYC_PER_US));
        chk(16'(cnt[2]), 16'h0000);
        chk(16'(cnt[3]), 16'(2 * CYC_PER_US));
        wr(OFS_INPUT_SEL, 16'h010C);
        rd(OFS_INPUT_SEL, 16'h010C);
        repeat (3) @(negedge clk);
        run(2'b01);
        chk(16'(cnt[0]), 16'h0000);
        $display("pulse done");
        wr(OFS_PATH_A, PATH_CODE_SKIP_ALL);
        repeat (3) @(negedge clk);
        run(2'b01);
        chk(16'(ts.size()), 16'h0004);
        foreach (ts[j]) chk(16'(ts[j]), 16'(1 + j * CYC_PER_US));
        $display("direct done");
        end_sim();
    end
endmodule : tb
bind apm_path_config apm_path_config_asserts apm_path_config_asserts_i (
    .clk, .rst_b, .reg_addr, .reg_wdata, .reg_wr, .bandpass_bypass, .integrator_bypass,
    .integrator_follower_on, .follower_gain_low, .transimpedance_bias_select,
    .integrator_setting, .direct_conversion_mode, .pulse_connect_mode,
    .input_switch_closed, .led_fire);
